//--- src/lbp_regs.vh
// Register map, field positions, reset values and timing for the LED
// pulse/breathe PWM block.
// Included by the design files of that block; definitions only.
`ifndef LBP_REGS_VH
`define LBP_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define LBP_ADDR_BREATHE_PERIOD 8'h86
`define LBP_ADDR_PULSE_CONFIG 8'h88
`define LBP_ADDR_FIRST_DUTY 8'h90
`define LBP_ADDR_SECOND_DUTY 8'h91
`define LBP_ADDR_BREATHE_DUTY 8'h92
`define LBP_ADDR_DIRECT_DUTY 8'h93
`define LBP_ADDR_RAMP_TIMES 8'h94

// ****************************************
// Reset values
// ****************************************
`define LBP_RST_BREATHE_PERIOD 7'h5d
`define LBP_RST_PULSE_CONFIG 7'h24
`define LBP_RST_DUTY 8'hf0
`define LBP_RST_RAMP_TIMES 6'h00

// ****************************************
// Field positions
// ****************************************
`define LBP_PERIOD_FIELD 6:0
`define LBP_RAMP_ALERT_BIT 6
`define LBP_SECOND_CNT_FIELD 5:3
`define LBP_FIRST_CNT_FIELD 2:0
`define LBP_DUTY_TOP_FIELD 7:4
`define LBP_DUTY_FLOOR_FIELD 3:0
`define LBP_RISE_FIELD 5:3
`define LBP_FALL_FIELD 2:0
`define LBP_CONFIG_FIELD 6:0
`define LBP_RAMP_FIELD 5:0

// ****************************************
// Behaviour selector codes
// ****************************************
`define LBP_MODE_DIRECT 2'h0
`define LBP_MODE_FIRST_PULSE 2'h1
`define LBP_MODE_SECOND_PULSE 2'h2
`define LBP_MODE_BREATHE 2'h3

// ****************************************
// Timing and sizes
// ****************************************
`define LBP_CLK_MHZ 20
`define LBP_PERIOD_LSB_US 32000
`define LBP_RAMP_STEP_US 250000
`define LBP_RAMP_LAST_CODE 3'h7
`define LBP_RAMP_LAST_MULT 32'h8
`define LBP_PWM_LAST 7'h63
`define LBP_LED_COUNT 11

`endif

//--- src/lbp_regfile.v
// Register file of the LED pulse/breathe PWM block.
// Assumes a single-cycle write strobe and address from the device's own
// register access logic on the same clock.
`timescale 1ns/1ps
`include "lbp_regs.vh"

module lbp_regfile
(
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Register access
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrite,
	output reg [7:0] regRdData,
	// Power state
	input wire deepSleepRequest,
	// Fields
	output reg [6:0] breathePeriodCode,
	output reg [6:0] pulseConfig,
	output reg [7:0] firstPulseDuty,
	output reg [7:0] secondPulseDuty,
	output reg [7:0] breatheDuty,
	output reg [7:0] directModeDuty,
	output reg [5:0] directRampTimes
);

	// ****************************************
	// Writes
	// ****************************************
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			breathePeriodCode <= `LBP_RST_BREATHE_PERIOD;
			pulseConfig <= `LBP_RST_PULSE_CONFIG;
			firstPulseDuty <= `LBP_RST_DUTY;
			secondPulseDuty <= `LBP_RST_DUTY;
			breatheDuty <= `LBP_RST_DUTY;
			directModeDuty <= `LBP_RST_DUTY;
			directRampTimes <= `LBP_RST_RAMP_TIMES;
		end
		else
		begin
			if (regWrite)
			begin
				case (regAddr)
					`LBP_ADDR_BREATHE_PERIOD: breathePeriodCode <= regWrData[`LBP_PERIOD_FIELD]; // RULE1
					`LBP_ADDR_PULSE_CONFIG: pulseConfig <= regWrData[`LBP_CONFIG_FIELD];
					`LBP_ADDR_FIRST_DUTY: firstPulseDuty <= regWrData; // RULE8
					`LBP_ADDR_SECOND_DUTY: secondPulseDuty <= regWrData;
					`LBP_ADDR_BREATHE_DUTY: breatheDuty <= regWrData;
					`LBP_ADDR_DIRECT_DUTY: directModeDuty <= regWrData;
					`LBP_ADDR_RAMP_TIMES: directRampTimes <= regWrData[`LBP_RAMP_FIELD];
					default: ;
				endcase
			end
			// Deep sleep overrides a same-cycle write of the alert enable
			if (deepSleepRequest)
				pulseConfig[`LBP_RAMP_ALERT_BIT] <= 1'b0; // RULE4
		end
	end

	// ****************************************
	// Reads, one cycle after the address
	// ****************************************
	always @(posedge core_clk)
	begin
		if (reset)
			regRdData <= 8'h00;
		else
		begin
			case (regAddr)
				`LBP_ADDR_BREATHE_PERIOD: regRdData <= {1'b0, breathePeriodCode};
				`LBP_ADDR_PULSE_CONFIG: regRdData <= {1'b0, pulseConfig};
				`LBP_ADDR_FIRST_DUTY: regRdData <= firstPulseDuty;
				`LBP_ADDR_SECOND_DUTY: regRdData <= secondPulseDuty;
				`LBP_ADDR_BREATHE_DUTY: regRdData <= breatheDuty;
				`LBP_ADDR_DIRECT_DUTY: regRdData <= directModeDuty;
				`LBP_ADDR_RAMP_TIMES: regRdData <= {2'h0, directRampTimes};
				default: regRdData <= 8'h00;
			endcase
		end
	end

endmodule

//--- src/lbp_pwm_top.v
// LED pulse/breathe PWM shaping for eleven low-side LED drivers.
// Assumes actuation, behaviour selectors and pulse periods come from
// other device logic on core_clk; no pin synchronisers are needed.
`timescale 1ns/1ps
`include "lbp_regs.vh"

// What this block does
// RULE1: Breathe period is seven bits of 32 ms
// RULE2: Breathe period only used by breathe code
// RULE3: Alert when control-started LED finishes, if enabled
// RULE4: Deep sleep clears the alert enable
// RULE5: Second pulse count in bits 5:3, reset five
// RULE6: First pulse count in bits 2:0
// RULE7: Pulse count equals field plus one
// RULE8: Each behaviour has top and floor duty nibbles
// RULE9: Duty ramps floor to top, then back
// RULE10: Direct mode takes new duty immediately
// RULE11: Other modes take settings at reactivation
// RULE12: Top duty code table seven to hundred
// RULE13: Floor duty code table zero to seventy-seven
// RULE14: Direct rise time field in bits 5:3
// RULE15: Direct fall time field in bits 2:0
// RULE16: Ramp codes give zero to two seconds
// RULE17: Software copies fall setting into rise
// RULE18: Breathe spends half period each way
// RULE19: Duty steps evenly across each ramp
module lbp_pwm_top
#(
	parameter [31:0] HALF_PERIOD_LSB_CYCLES = `LBP_PERIOD_LSB_US * `LBP_CLK_MHZ / 2,
	parameter [31:0] RAMP_STEP_CYCLES = `LBP_RAMP_STEP_US * `LBP_CLK_MHZ
)
(
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Register access
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrite,
	output wire [7:0] regRdData,
	// Device state and per-LED control
	input wire deepSleepRequest,
	input wire [2*`LBP_LED_COUNT-1:0] ledBehaviourSelector,
	input wire [`LBP_LED_COUNT-1:0] ledActuate,
	input wire [`LBP_LED_COUNT-1:0] ledByControl,
	input wire [6:0] firstPulsePeriodCode,
	input wire [6:0] secondPulsePeriodCode,
	// Outputs
	output wire [`LBP_LED_COUNT-1:0] ledPwm,
	output reg alert
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_UP = 2'h1;
	localparam [1:0] ST_HOLD = 2'h2;
	localparam [1:0] ST_DOWN = 2'h3;

	// ****************************************
	// Decode functions
	// ****************************************
	// Duty in percent for a top-duty code
	function [6:0] dutyPct;
		input [3:0] code;
		begin
			case (code) // RULE12
				4'h0: dutyPct = 7'h07;
				4'h1: dutyPct = 7'h09;
				4'h2: dutyPct = 7'h0b;
				4'h3: dutyPct = 7'h0e;
				4'h4: dutyPct = 7'h11;
				4'h5: dutyPct = 7'h14;
				4'h6: dutyPct = 7'h17;
				4'h7: dutyPct = 7'h1a;
				4'h8: dutyPct = 7'h1e;
				4'h9: dutyPct = 7'h23;
				4'ha: dutyPct = 7'h28;
				4'hb: dutyPct = 7'h2e;
				4'hc: dutyPct = 7'h35;
				4'hd: dutyPct = 7'h3f;
				4'he: dutyPct = 7'h4d;
				default: dutyPct = 7'h64;
			endcase
		end
	endfunction

	// Floor table is the top table shifted by one, with zero first
	function [6:0] floorPct;
		input [3:0] code;
		begin
			if (code == 4'h0)
				floorPct = 7'h00; // RULE13
			else
				floorPct = dutyPct(code - 4'h1); // RULE13
		end
	endfunction

	// Half of a period code; code zero behaves as one step
	function [31:0] halfCycles;
		input [6:0] code;
		begin
			if (code == 7'h00)
				halfCycles = HALF_PERIOD_LSB_CYCLES; // RULE1
			else
				halfCycles = {25'h0, code} * HALF_PERIOD_LSB_CYCLES; // RULE1 RULE18
		end
	endfunction

	// Direct ramp time; the last code jumps to eight steps
	function [31:0] rampCycles;
		input [2:0] code;
		begin
			if (code == `LBP_RAMP_LAST_CODE)
				rampCycles = `LBP_RAMP_LAST_MULT * RAMP_STEP_CYCLES; // RULE16
			else
				rampCycles = {29'h0, code} * RAMP_STEP_CYCLES; // RULE16
		end
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	wire [6:0] breathePeriodCode;
	wire [6:0] pulseConfig;
	wire [7:0] firstPulseDuty;
	wire [7:0] secondPulseDuty;
	wire [7:0] breatheDuty;
	wire [7:0] directModeDuty;
	wire [5:0] directRampTimes;

	lbp_regfile uRegs
	(
		.core_clk(core_clk),
		.reset(reset),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWrite(regWrite),
		.regRdData(regRdData),
		.deepSleepRequest(deepSleepRequest),
		.breathePeriodCode(breathePeriodCode),
		.pulseConfig(pulseConfig),
		.firstPulseDuty(firstPulseDuty),
		.secondPulseDuty(secondPulseDuty),
		.breatheDuty(breatheDuty),
		.directModeDuty(directModeDuty),
		.directRampTimes(directRampTimes)
	);

	// ****************************************
	// Shared settings per behaviour
	// ****************************************
	wire [2:0] second_pulse_count = pulseConfig[`LBP_SECOND_CNT_FIELD]; // RULE5
	wire [2:0] first_pulse_count = pulseConfig[`LBP_FIRST_CNT_FIELD]; // RULE6
	wire [3:0] firstPulses = {1'b0, first_pulse_count} + 4'h1; // RULE7
	wire [3:0] secondPulses = {1'b0, second_pulse_count} + 4'h1; // RULE7
	wire [6:0] firstTop = dutyPct(firstPulseDuty[`LBP_DUTY_TOP_FIELD]); // RULE8
	wire [6:0] firstFloor = floorPct(firstPulseDuty[`LBP_DUTY_FLOOR_FIELD]);
	wire [6:0] secondTop = dutyPct(secondPulseDuty[`LBP_DUTY_TOP_FIELD]);
	wire [6:0] secondFloor = floorPct(secondPulseDuty[`LBP_DUTY_FLOOR_FIELD]);
	wire [6:0] breatheTop = dutyPct(breatheDuty[`LBP_DUTY_TOP_FIELD]);
	wire [6:0] breatheFloor = floorPct(breatheDuty[`LBP_DUTY_FLOOR_FIELD]);
	wire [6:0] directTop = dutyPct(directModeDuty[`LBP_DUTY_TOP_FIELD]);
	wire [6:0] directFloor = floorPct(directModeDuty[`LBP_DUTY_FLOOR_FIELD]);
	wire [31:0] firstHalf = halfCycles(firstPulsePeriodCode);
	wire [31:0] secondHalf = halfCycles(secondPulsePeriodCode);
	wire [31:0] breatheHalf = halfCycles(breathePeriodCode);
	wire [31:0] riseCycles = rampCycles(directRampTimes[`LBP_RISE_FIELD]); // RULE14
	wire [31:0] fallCycles = rampCycles(directRampTimes[`LBP_FALL_FIELD]); // RULE15

	// ****************************************
	// PWM phase, 100 steps of one percent
	// ****************************************
	reg [6:0] pwmPhase;

	always @(posedge core_clk)
	begin
		if (reset || pwmPhase == `LBP_PWM_LAST)
			pwmPhase <= 7'h00;
		else
			pwmPhase <= pwmPhase + 7'h01;
	end

	// ****************************************
	// Per-LED behaviour engines
	// ****************************************
	wire [`LBP_LED_COUNT-1:0] ledDone;

	genvar i;
	generate
		for (i = 0; i < `LBP_LED_COUNT; i = i + 1)
		begin : gLed
			wire act = ledActuate[i];
			wire [1:0] mode = ledBehaviourSelector[2*i+1:2*i];
			reg [6:0] modeFloor;
			reg [6:0] modeTop;
			reg [31:0] modeUp;
			reg [31:0] modeDown;
			reg [3:0] modePulses;
			reg [1:0] state;
			reg [1:0] runMode;
			reg [6:0] latFloor;
			reg [6:0] latTop;
			reg [31:0] latUp;
			reg [31:0] latDown;
			reg [3:0] latPulses;
			reg [3:0] pulsesLeft;
			reg released;
			reg prevAct;
			reg [6:0] duty;
			reg [31:0] timer;
			reg [31:0] acc;
			reg pwmBit;
			reg doneBit;

			always @*
			begin
				case (mode)
					`LBP_MODE_FIRST_PULSE:
					begin
						modeFloor = firstFloor;
						modeTop = firstTop;
						modeUp = firstHalf;
						modeDown = firstHalf;
						modePulses = firstPulses;
					end
					`LBP_MODE_SECOND_PULSE:
					begin
						modeFloor = secondFloor;
						modeTop = secondTop;
						modeUp = secondHalf;
						modeDown = secondHalf;
						modePulses = secondPulses;
					end
					`LBP_MODE_BREATHE:
					begin
						modeFloor = breatheFloor;
						modeTop = breatheTop;
						modeUp = breatheHalf; // RULE2 RULE18
						modeDown = breatheHalf; // RULE18
						modePulses = 4'h1;
					end
					default:
					begin
						modeFloor = directFloor;
						modeTop = directTop;
						modeUp = riseCycles;
						modeDown = fallCycles;
						modePulses = 4'h1;
					end
				endcase
			end

			// Direct runs from live settings, the rest from the copy taken at start
			wire live = (runMode == `LBP_MODE_DIRECT);
			wire [6:0] curFloor = live ? modeFloor : latFloor; // RULE10 RULE11
			wire [6:0] curTop = live ? modeTop : latTop; // RULE10 RULE11
			wire [31:0] phaseLen = (state == ST_UP) ? (live ? modeUp : latUp) : (live ? modeDown : latDown);
			wire [6:0] span = (curTop > curFloor) ? (curTop - curFloor) : 7'h00;
			wire [31:0] accSum = acc + {25'h0, span};
			wire stepNow = (accSum >= phaseLen);
			wire phaseEnd = (phaseLen == 32'h0) || (timer >= phaseLen - 32'h1);
			wire startNow = (mode == `LBP_MODE_DIRECT) ? act : (act && !prevAct);
			wire lastBreath = (pulsesLeft == 4'h1);

			always @(posedge core_clk)
			begin
				if (reset)
				begin
					state <= ST_IDLE;
					runMode <= `LBP_MODE_DIRECT;
					latFloor <= 7'h00;
					latTop <= 7'h00;
					latUp <= 32'h0;
					latDown <= 32'h0;
					latPulses <= 4'h1;
					pulsesLeft <= 4'h1;
					released <= 1'b0;
					prevAct <= 1'b0;
					duty <= 7'h00;
					timer <= 32'h0;
					acc <= 32'h0;
					doneBit <= 1'b0;
				end
				else
				begin
					prevAct <= act;
					doneBit <= 1'b0;
					timer <= timer + 32'h1;
					// Spread span steps evenly over the phase length
					if (stepNow)
						acc <= accSum - phaseLen; // RULE19
					else
						acc <= accSum; // RULE19
					case (state)
						ST_IDLE:
						begin
							duty <= modeFloor;
							runMode <= mode;
							if (startNow)
							begin
								state <= ST_UP;
								latFloor <= modeFloor; // RULE11
								latTop <= modeTop;
								latUp <= modeUp;
								latDown <= modeDown;
								latPulses <= modePulses;
								pulsesLeft <= modePulses;
								released <= 1'b0;
								timer <= 32'h0;
								acc <= 32'h0;
							end
						end
						ST_UP:
						begin
							if (live && !act)
							begin
								state <= ST_DOWN;
								timer <= 32'h0;
								acc <= 32'h0;
							end
							else if (phaseEnd)
							begin
								duty <= curTop; // RULE9
								state <= live ? ST_HOLD : ST_DOWN;
								timer <= 32'h0;
								acc <= 32'h0;
							end
							else if (stepNow && duty < curTop)
								duty <= duty + 7'h01; // RULE9 RULE19
						end
						ST_HOLD:
						begin
							duty <= curTop; // RULE10
							if (!act)
							begin
								state <= ST_DOWN;
								timer <= 32'h0;
								acc <= 32'h0;
							end
						end
						default:
						begin
							if (phaseEnd)
							begin
								duty <= curFloor; // RULE9
								timer <= 32'h0;
								acc <= 32'h0;
								case (runMode)
									`LBP_MODE_FIRST_PULSE:
									begin
										pulsesLeft <= pulsesLeft - 4'h1;
										state <= lastBreath ? ST_IDLE : ST_UP;
										doneBit <= lastBreath;
									end
									`LBP_MODE_SECOND_PULSE:
									begin
										if (released || !act)
										begin
											pulsesLeft <= pulsesLeft - 4'h1;
											state <= lastBreath ? ST_IDLE : ST_UP;
											doneBit <= lastBreath;
										end
										else
											state <= ST_UP;
									end
									default:
									begin
										state <= act ? ST_UP : ST_IDLE;
										doneBit <= !act;
									end
								endcase
							end
							else if (stepNow && duty > curFloor)
								duty <= duty - 7'h01; // RULE9 RULE19
						end
					endcase
					// Release in the second pulse behaviour arms the trailing count
					if (runMode == `LBP_MODE_SECOND_PULSE && state != ST_IDLE && !released && !act)
					begin
						released <= 1'b1;
						if (!(state == ST_DOWN && phaseEnd))
							pulsesLeft <= latPulses;
						else if (lastBreath)
							pulsesLeft <= latPulses;
					end
				end
			end

			always @(posedge core_clk)
			begin
				if (reset)
					pwmBit <= 1'b0;
				else
					pwmBit <= (pwmPhase < duty);
			end

			assign ledPwm[i] = pwmBit;
			assign ledDone[i] = doneBit;
		end
	endgenerate

	// ****************************************
	// Alert on completion
	// ****************************************
	// One-cycle pulse; any latching of the alert pin is done downstream
	always @(posedge core_clk)
	begin
		if (reset)
			alert <= 1'b0;
		else
			alert <= pulseConfig[`LBP_RAMP_ALERT_BIT] && |(ledDone & ledByControl); // RULE3
	end

endmodule

//--- bench/lbp_pwm_asserts.sv
// Port checks for the LED pulse/breathe PWM top, bound into every instance.
// Assumes one core_clk domain with synchronous active-high reset.
`timescale 1ns/1ps
`include "lbp_regs.vh"

module lbp_pwm_asserts
#(
	parameter [31:0] HALF_PERIOD_LSB_CYCLES = 32'h32,
	parameter [31:0] RAMP_STEP_CYCLES = 32'h64
)
(
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Register access
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrite,
	input wire [7:0] regRdData,
	// Device state and per-LED control
	input wire deepSleepRequest,
	input wire [2*`LBP_LED_COUNT-1:0] ledBehaviourSelector,
	input wire [`LBP_LED_COUNT-1:0] ledActuate,
	input wire [`LBP_LED_COUNT-1:0] ledByControl,
	input wire [6:0] firstPulsePeriodCode,
	input wire [6:0] secondPulsePeriodCode,
	// Outputs
	input wire [`LBP_LED_COUNT-1:0] ledPwm,
	input wire alert
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	// ****************************************
	// Shadow of the period, config and ramp fields
	// ****************************************
	logic alertEn;
	logic [6:0] periodSh;
	logic [5:0] countSh;
	logic [5:0] rampSh;
	always @(posedge core_clk)
	begin
		if (reset || deepSleepRequest)
			alertEn <= 1'b0;
		else if (regWrite && regAddr == 8'h88)
			alertEn <= regWrData[6];
		if (regWrite && regAddr == 8'h86)
			periodSh <= regWrData[6:0];
		if (regWrite && regAddr == 8'h88)
			countSh <= regWrData[5:0];
		if (regWrite && regAddr == 8'h94)
			rampSh <= regWrData[5:0];
	end

	// ****************************************
	// Properties
	// ****************************************
	property p_reset_quiet;
		$past(reset) |-> ledPwm == 11'h000 && !alert && regRdData == 8'h00;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
	property p_period_wr_rd;
		regWrite && regAddr == 8'h86 ##1 regAddr == 8'h86 && !regWrite |=> regRdData == {1'b0, periodSh};
	endproperty
	a_period_wr_rd: assert property (p_period_wr_rd) else $error("period read-back wrong");
	property p_config_wr_rd;
		regWrite && regAddr == 8'h88 ##1 regAddr == 8'h88 && !regWrite && !deepSleepRequest
			|=> regRdData == {1'b0, alertEn, countSh};
	endproperty
	a_config_wr_rd: assert property (p_config_wr_rd) else $error("config read-back wrong");
	property p_ramp_wr_rd;
		regWrite && regAddr == 8'h94 ##1 regAddr == 8'h94 && !regWrite |=> regRdData == {2'b00, rampSh};
	endproperty
	a_ramp_wr_rd: assert property (p_ramp_wr_rd) else $error("ramp read-back wrong");
	property p_alert_pulse;
		alert |=> !alert;
	endproperty
	a_alert_pulse: assert property (p_alert_pulse) else $error("alert longer than a cycle");
	property p_alert_enabled;
		alert |-> $past(alertEn) || $past(alertEn, 2) || $past(alertEn, 3);
	endproperty
	a_alert_enabled: assert property (p_alert_enabled) else $error("alert while disabled");
	property p_sleep_quiet;
		deepSleepRequest[*4] |-> !alert;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("alert in deep sleep");
	property p_sleep_reads_clear;
		deepSleepRequest[*2] ##0 regAddr == 8'h88 |=> !regRdData[6];
	endproperty
	a_sleep_reads_clear: assert property (p_sleep_reads_clear) else $error("enable kept in sleep");

	c_alert: cover property (alert);
	c_sleep_read: cover property (deepSleepRequest && regAddr == 8'h88);
	c_ramp_write: cover property (regWrite && regAddr == 8'h94);
endmodule

bind lbp_pwm_top lbp_pwm_asserts #(.HALF_PERIOD_LSB_CYCLES(HALF_PERIOD_LSB_CYCLES),
	.RAMP_STEP_CYCLES(RAMP_STEP_CYCLES)) u_lbpChk (.core_clk(core_clk), .reset(reset),
	.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRdData(regRdData),
	.deepSleepRequest(deepSleepRequest), .ledBehaviourSelector(ledBehaviourSelector),
	.ledActuate(ledActuate), .ledByControl(ledByControl), .firstPulsePeriodCode(firstPulsePeriodCode),
	.secondPulsePeriodCode(secondPulsePeriodCode), .ledPwm(ledPwm), .alert(alert));

//--- bench/lbp_led_model.sv
// LED meter: lit cycles of each PWM output over 100-cycle windows.
// Assumes a steady duty spans at least two whole windows before it is read.
`timescale 1ns/1ps
`include "lbp_regs.vh"

module lbp_led_model
(
	// Clock
	input wire core_clk,
	// LED drive
	input wire [`LBP_LED_COUNT-1:0] ledPwm,
	// Percent lit per LED, 7 bits each
	output logic [7*`LBP_LED_COUNT-1:0] dutySeen
);
	logic [6:0] slot = 7'h00;
	logic [6:0] litCnt [`LBP_LED_COUNT];
	initial
	begin
		dutySeen = '0;
		for (int i = 0; i < `LBP_LED_COUNT; i++)
			litCnt[i] = 7'h00;
	end
	always @(posedge core_clk)
	begin
		for (int i = 0; i < `LBP_LED_COUNT; i++)
		begin
			if (slot == 7'h63)
			begin
				dutySeen[7*i +: 7] <= litCnt[i] + {6'h00, ledPwm[i]};
				litCnt[i] <= 7'h00;
			end
			else
				litCnt[i] <= litCnt[i] + {6'h00, ledPwm[i]};
		end
		slot <= (slot == 7'h63) ? 7'h00 : slot + 7'h01;
	end
endmodule

//--- bench/test_lbp_pwm_top.sv
// Self-checking bench for the LED pulse/breathe PWM top.
// Assumes shortened period and ramp parameters and the LED meter on ledPwm.
`timescale 1ns/1ps
`include "lbp_regs.vh"

module test_lbp_pwm_top;
	localparam int HALF = 50;
	localparam int STEP = 100;
	localparam time DLY = 1;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrite = 1'b0;
	logic deepSleepRequest = 1'b0;
	// LED0 direct, LED1 first pulse, LED2 breathe, LED3 second pulse
	logic [2*`LBP_LED_COUNT-1:0] ledBehaviourSelector = 22'h0000b4;
	logic [`LBP_LED_COUNT-1:0] ledActuate = 11'h000;
	logic [`LBP_LED_COUNT-1:0] ledByControl = 11'h000;
	logic [6:0] firstPulsePeriodCode = 7'h01;
	logic [6:0] secondPulsePeriodCode = 7'h01;
	wire [7:0] regRdData;
	wire [`LBP_LED_COUNT-1:0] ledPwm;
	wire alert;
	wire [7*`LBP_LED_COUNT-1:0] dutySeen;
	int errorCnt = 0;
	int nCompared = 0;
	int took;
	int lo;
	// Address, reset value, write data, read-back
	logic [31:0] regRows [8] = '{32'h865dff7f, 32'h88243f3f, 32'h90f0a5a5, 32'h91f05a5a,
		32'h92f0c3c3, 32'h93f03c3c, 32'h9400ff3f, 32'h8700ff00};
	// Duty code, top percent, floor percent
	logic [23:0] dutyRows [16] = '{24'h000700, 24'h010907, 24'h020b09, 24'h030e0b, 24'h04110e,
		24'h051411, 24'h061714, 24'h071a17, 24'h081e1a, 24'h09231e, 24'h0a2823, 24'h0b2e28,
		24'h0c352e, 24'h0d3f35, 24'h0e4d3f, 24'h0f644d};
	// LED, Led_pulse_config byte, breaths until alert (0: none)
	logic [23:0] alertRows [4] = '{24'h014001, 24'h014708, 24'h034802, 24'h010700};

	always #25 core_clk = ~core_clk;

	lbp_pwm_top #(.HALF_PERIOD_LSB_CYCLES(HALF), .RAMP_STEP_CYCLES(STEP)) i_dut (.core_clk(core_clk),
		.reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRdData(regRdData),
		.deepSleepRequest(deepSleepRequest), .ledBehaviourSelector(ledBehaviourSelector),
		.ledActuate(ledActuate), .ledByControl(ledByControl), .firstPulsePeriodCode(firstPulsePeriodCode),
		.secondPulsePeriodCode(secondPulsePeriodCode), .ledPwm(ledPwm), .alert(alert));
	lbp_led_model i_leds (.core_clk(core_clk), .ledPwm(ledPwm), .dutySeen(dutySeen));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		nCompared++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#DLY;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		tick(1);
		regAddr = a;
		regWrData = d;
		regWrite = 1'b1;
		tick(1);
		regWrite = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
		tick(1);
		regAddr = a;
		tick(1);
		check(regRdData, e, what);
	endtask
	// Actuates one LED from the control bits and counts cycles until alert
	task automatic runLed(input int idx, input int hold, output int cyc);
		cyc = 0;
		ledActuate[idx] = 1'b1;
		ledByControl[idx] = 1'b1;
		for (int n = 1; n <= 3000 && cyc == 0; n++)
		begin
			tick(1);
			if (n == hold)
				ledActuate[idx] = 1'b0;
			if (alert === 1'b1)
				cyc = n;
		end
		ledActuate[idx] = 1'b0;
		ledByControl[idx] = 1'b0;
		tick(20);
	endtask
	task automatic endTest(input string name);
		$display("test %s done, %0d mismatches so far", name, errorCnt);
	endtask
	task automatic stopTest;
		$display("compared %0d, mismatches %0d", nCompared, errorCnt);
		if (errorCnt == 0 && nCompared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		#(40000 * 50);
		errorCnt++;
		$display("unexpected at %0t: watchdog expired", $time);
		stopTest;
	end

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		tick(12);
		reset = 1'b0;
		for (int k = 0; k < 8; k++)
		begin
			rd(regRows[k][31:24], regRows[k][23:16], "reset value");
			wr(regRows[k][31:24], regRows[k][15:8]);
			rd(regRows[k][31:24], regRows[k][7:0], "read-back");
		end
		endTest("registers");
		wr(8'h94, 8'h00);
		// Direct duty rewritten live while held, then while released
		for (int k = 0; k < 32; k++)
		begin
			ledActuate[0] = (k < 16);
			wr(8'h93, {dutyRows[k % 16][19:16], dutyRows[k % 16][19:16]});
			tick(250);
			check(dutySeen[6:0], (k < 16) ? dutyRows[k % 16][15:8] : dutyRows[k % 16][7:0], "duty");
		end
		endTest("duty tables");
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h88, alertRows[k][15:8]);
			runLed(alertRows[k][23:16], 5, took);
			lo = alertRows[k][7:0] * 2 * HALF;
			check((lo == 0) ? (took == 0) : (took >= lo && took <= lo + 6), 1'b1, "pulse alert");
		end
		wr(8'h86, 8'h02);
		wr(8'h88, 8'h40);
		// Period rewritten mid-breath must not stretch the running breath
		fork
			runLed(2, 50, took);
			begin
				tick(20);
				wr(8'h86, 8'h05);
			end
		join
		check(took >= 4 * HALF && took <= 4 * HALF + 6, 1'b1, "breathe alert");
		endTest("alerts");
		deepSleepRequest = 1'b1;
		wr(8'h88, 8'h7f);
		rd(8'h88, 8'h3f, "sleep write");
		deepSleepRequest = 1'b0;
		wr(8'h88, 8'h40);
		deepSleepRequest = 1'b1;
		tick(3);
		deepSleepRequest = 1'b0;
		rd(8'h88, 8'h00, "sleep clear");
		runLed(1, 5, took);
		check(took, 0, "alert after sleep");
		// Direct fall: software copies the fall code into rise while the LED is lit
		wr(8'h88, 8'h40);
		wr(8'h94, 8'h01);
		ledActuate[0] = 1'b1;
		ledByControl[0] = 1'b1;
		wr(8'h94, 8'h09);
		tick(200);
		ledActuate[0] = 1'b0;
		took = 0;
		for (int n = 1; n <= 300 && took == 0; n++)
		begin
			tick(1);
			if (alert === 1'b1)
				took = n;
		end
		ledByControl[0] = 1'b0;
		check(took >= STEP && took <= STEP + 6, 1'b1, "direct fall");
		endTest("direct fall");
		wr(8'h88, 8'h7f);
		reset = 1'b1;
		tick(2);
		reset = 1'b0;
		rd(8'h88, 8'h24, "second reset");
		endTest("sleep and reset");
		stopTest;
	end
endmodule
